// File: core/wdrt_pkg.sv
// Purpose : shared constants and carrier types for the watchdog reset timer
// Assumes : single 50 MHz core clock
// Notes   : no software-reachable registers; control arrives as plain ports

package wdrt_pkg;

    // ----------------------------------------------------------------
    // counter geometry
    // ----------------------------------------------------------------
    localparam int unsigned WDRT_CNT_W   = 16;
    localparam int unsigned WDRT_BYTE_W  = 8;
    localparam int unsigned WDRT_HI_LSB  = 8;

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    localparam int unsigned WDRT_DIV_SLOW  = 128;
    localparam int unsigned WDRT_DIV_FAST  = 2;
    localparam int unsigned WDRT_PRE_W     = 7;
    localparam logic [6:0]  WDRT_PRE_FAST_MAX = 7'h01;
    localparam logic [6:0]  WDRT_PRE_SLOW_MAX = 7'h7f;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] WDRT_CNT_RST    = 16'h0000;
    localparam logic [7:0]  WDRT_RELOAD_RST = 8'h00;
    localparam logic        WDRT_PRE_RST    = 1'b0;

    // ----------------------------------------------------------------
    // reset pulse length on overflow
    // ----------------------------------------------------------------
    localparam int unsigned WDRT_RST_PULSE_NS = 100;
    localparam int unsigned WDRT_CLK_PERIOD_NS = 20;
    localparam int unsigned WDRT_RST_PULSE_CYC =
        (WDRT_RST_PULSE_NS + WDRT_CLK_PERIOD_NS - 1) / WDRT_CLK_PERIOD_NS;
    localparam int unsigned WDRT_RST_CNT_W = 4;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       service;
        logic       disable_req;
        logic       end_of_init_instruction;
        logic       prescale_slow;
        logic       reload_we;
        logic [7:0] reload_value_field;
    } wdrt_ctrl_t;

    typedef struct packed {
        logic        running;
        logic        init_done;
        logic        overflow;
        logic [15:0] count;
    } wdrt_stat_t;

    typedef enum logic [1:0] {
        WDRT_ST_INIT,
        WDRT_ST_RUN,
        WDRT_ST_OFF,
        WDRT_ST_RESET
    } wdrt_state_t;

endpackage

// File: core/wdrt_prescaler.sv
// Purpose : tick generator dividing the core clock by 2 or 128
// Assumes : clear restarts the division phase
// Notes   : tick is one cycle wide

`timescale 1ns/100ps
`default_nettype none

module wdrt_prescaler
    import wdrt_pkg::*;
(
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    input  wire logic clk_en_i,
    // control
    input  wire logic run_i,
    input  wire logic clear_i,
    input  wire logic slow_i,
    // tick
    output var  logic tick_o
);
    logic [WDRT_PRE_W-1:0] pre_r;
    logic [WDRT_PRE_W-1:0] pre_nxt;
    logic                  tick_r;
    logic                  tick_nxt;
    logic [WDRT_PRE_W-1:0] pre_max;

    always_comb
    begin
        pre_max  = slow_i ? WDRT_PRE_SLOW_MAX : WDRT_PRE_FAST_MAX;
        pre_nxt  = pre_r;
        tick_nxt = 1'b0;
        if (clear_i || !run_i)
        begin
            pre_nxt = '0;
        end
        else if (pre_r >= pre_max)
        begin
            pre_nxt  = '0;
            tick_nxt = 1'b1;
        end
        else
        begin
            pre_nxt = pre_r + 7'h01;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            pre_r  <= '0;
            tick_r <= 1'b0;
        end
        else if (clk_en_i)
        begin
            pre_r  <= pre_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;

endmodule

`default_nettype wire

// File: core/wdrt_top.sv
// Purpose : watchdog reset timer supervising start-up and running software
// Assumes : control strobes are one-cycle pulses synchronous to core_clk_i
// Notes   : overflow raises an internal reset pulse and pulls the reset pin low

`timescale 1ns/100ps
`default_nettype none

// Operation
// - any reset leaves the watchdog armed and counting without software action
// - disable honoured only before end-of-init; afterwards ignored until reset
// - counter overflow issues an internal hardware reset pulse
// - overflow also drives the reset output pin low
// - 16-bit up-counter; carry out of bit 15 is the overflow
// - counter advances at clock divided by 2 or 128, software selected
// - each service loads the upper byte from the reload value
// - prescaler and reload together span short to long supervised intervals
// - reset defaults give the full-count default interval
module wdrt_top
    import wdrt_pkg::*;
#(
    parameter int unsigned RST_PULSE_CYC = WDRT_RST_PULSE_CYC
)
(
    // clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                clk_en_i,
    // software control
    input  wire wdrt_pkg::wdrt_ctrl_t ctrl_i,
    // reset outputs
    output var  logic                chip_reset_o,
    output var  logic                reset_output_pin_n_o,
    // status
    output var  wdrt_pkg::wdrt_stat_t stat_o
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    wdrt_state_t               state_r;
    wdrt_state_t               state_nxt;
    logic [WDRT_CNT_W-1:0]     cnt_r;
    logic [WDRT_CNT_W-1:0]     cnt_nxt;
    logic [WDRT_BYTE_W-1:0]    reload_r;
    logic [WDRT_BYTE_W-1:0]    reload_nxt;
    logic                      slow_r;
    logic                      slow_nxt;
    logic [WDRT_RST_CNT_W-1:0] pulse_r;
    logic [WDRT_RST_CNT_W-1:0] pulse_nxt;
    logic                      chip_rst_r;
    logic                      chip_rst_nxt;
    logic                      pin_n_r;
    logic                      pin_n_nxt;
    wdrt_stat_t                stat_r;
    wdrt_stat_t                stat_nxt;
    logic                      tick;
    logic                      running;
    logic [WDRT_CNT_W:0]       cnt_inc;
    logic                      rearm;

    assign running = (state_r == WDRT_ST_INIT) || (state_r == WDRT_ST_RUN);
    // last cycle of the overflow pulse: block restarts as if freshly reset
    assign rearm   = (state_r == WDRT_ST_RESET) && (pulse_r <= WDRT_RST_CNT_W'(1));

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    wdrt_prescaler u_pre (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .clk_en_i   (clk_en_i),
        .run_i      (running),
        .clear_i    (ctrl_i.service),
        .slow_i     (slow_r),
        .tick_o     (tick)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        pulse_nxt    = pulse_r;
        chip_rst_nxt = 1'b0;
        pin_n_nxt    = 1'b1;
        cnt_inc      = {1'b0, cnt_r} + 17'h0_0001;

        unique case (state_r)
            WDRT_ST_INIT,
            WDRT_ST_RUN:
            begin
                if (state_r == WDRT_ST_INIT && ctrl_i.disable_req)
                begin
                    state_nxt = WDRT_ST_OFF;
                end
                else if (ctrl_i.service)
                begin
                    cnt_nxt = {reload_r, {WDRT_BYTE_W{1'b0}}};
                end
                else if (tick)
                begin
                    cnt_nxt = cnt_inc[WDRT_CNT_W-1:0];
                    if (cnt_inc[WDRT_CNT_W])
                    begin
                        state_nxt    = WDRT_ST_RESET;
                        pulse_nxt    = WDRT_RST_CNT_W'(RST_PULSE_CYC);
                        chip_rst_nxt = 1'b1;
                        pin_n_nxt    = 1'b0;
                    end
                end
                // end-of-init locks out any later disable
                if (state_r == WDRT_ST_INIT && ctrl_i.end_of_init_instruction
                    && !ctrl_i.disable_req)
                begin
                    state_nxt = (state_nxt == WDRT_ST_RESET) ? WDRT_ST_RESET : WDRT_ST_RUN;
                end
            end
            WDRT_ST_OFF:
            begin
                // stopped watchdog still sees end-of-init; nothing to do
                cnt_nxt = cnt_r;
            end
            WDRT_ST_RESET:
            begin
                // hold both reset outputs for the pulse length
                chip_rst_nxt = 1'b1;
                pin_n_nxt    = 1'b0;
                if (pulse_r <= WDRT_RST_CNT_W'(1))
                begin
                    // internal reset re-arms with defaults
                    state_nxt    = WDRT_ST_INIT;
                    cnt_nxt      = WDRT_CNT_RST;
                    pulse_nxt    = '0;
                    chip_rst_nxt = 1'b0;
                    pin_n_nxt    = 1'b1;
                end
                else
                begin
                    pulse_nxt = pulse_r - WDRT_RST_CNT_W'(1);
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // settings: reload value and prescaler choice
    // ----------------------------------------------------------------
    // loadable in any cycle but the re-arm one, where the reset defaults restored after an overflow win
    always_comb
    begin
        reload_nxt = reload_r;
        slow_nxt   = slow_r;
        if (rearm)
        begin
            reload_nxt = WDRT_RELOAD_RST;
            slow_nxt   = WDRT_PRE_RST;
        end
        else if (ctrl_i.reload_we)
        begin
            reload_nxt = ctrl_i.reload_value_field;
            slow_nxt   = ctrl_i.prescale_slow;
        end
    end

    // ----------------------------------------------------------------
    // status mirror
    // ----------------------------------------------------------------
    // built from next values so stat_o lines up with the state flops
    always_comb
    begin
        stat_nxt.running   = (state_nxt == WDRT_ST_INIT) || (state_nxt == WDRT_ST_RUN);
        stat_nxt.init_done = (state_nxt == WDRT_ST_RUN);
        stat_nxt.overflow  = (state_nxt == WDRT_ST_RESET);
        stat_nxt.count     = cnt_nxt;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // reset defaults: armed, full 16-bit span at divide-by-2
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_r    <= WDRT_ST_INIT;
            cnt_r      <= WDRT_CNT_RST;
            pulse_r    <= '0;
            chip_rst_r <= 1'b0;
            pin_n_r    <= 1'b1;
        end
        else if (clk_en_i)
        begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            pulse_r    <= pulse_nxt;
            chip_rst_r <= chip_rst_nxt;
            pin_n_r    <= pin_n_nxt;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            reload_r <= WDRT_RELOAD_RST;
            slow_r   <= WDRT_PRE_RST;
        end
        else if (clk_en_i)
        begin
            reload_r <= reload_nxt;
            slow_r   <= slow_nxt;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            stat_r <= '{running: 1'b1, init_done: 1'b0, overflow: 1'b0, count: WDRT_CNT_RST};
        end
        else if (clk_en_i)
        begin
            stat_r <= stat_nxt;
        end
    end

    assign chip_reset_o         = chip_rst_r;
    assign reset_output_pin_n_o = pin_n_r;
    assign stat_o               = stat_r;

endmodule

`default_nettype wire

// File: tb/tb_top.sv
// Purpose : directed bench for the watchdog reset timer
// Assumes : reset pulse shortened to 2 cycles
// Notes   : prints only mismatches and the verdict
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import wdrt_pkg::*;
    localparam int unsigned PULSE = 2;
    localparam logic [12:0] M_SVC = 13'h1000;
    localparam logic [12:0] M_DIS = 13'h0800;
    localparam logic [12:0] M_EOI = 13'h0400;
    localparam logic [12:0] M_RWE = 13'h0100;
    localparam logic [12:0] M_STB = 13'h1D00;
    logic        core_clk_i = 1'b0;
    logic        rst_n_i    = 1'b0;
    logic        clk_en_i   = 1'b1;
    wdrt_ctrl_t  ctrl_i     = '0;
    logic        chip_reset_o;
    logic        reset_output_pin_n_o;
    wdrt_stat_t  stat_o;
    logic [15:0] seen;
    int          n;
    int          failures    = 0;
    int          checks_done = 0;
    always #10 core_clk_i = ~core_clk_i;
    wdrt_top #(.RST_PULSE_CYC(PULSE)) dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
        .ctrl_i(ctrl_i), .chip_reset_o(chip_reset_o), .reset_output_pin_n_o(reset_output_pin_n_o), .stat_o(stat_o));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk_i);
        #2;
    endtask
    // one assignment swaps the strobe; drop ends the run of pulses
    task automatic pulse(input logic [12:0] m);
        ctrl_i = (ctrl_i & ~M_STB) | m;
        tick(1);
    endtask
    task automatic drop;
        ctrl_i = ctrl_i & ~M_STB;
    endtask
    task automatic do_reset;
        rst_n_i = 1'b0;
        tick(6);
        rst_n_i = 1'b1;
    endtask
    // always followed by a pulse, which lowers the write strobe
    task automatic set_reload(input logic [7:0] v, input logic s);
        ctrl_i = {3'b000, s, 1'b1, v};
        tick(1);
    endtask
    task automatic wrap_up;
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic t_defaults;
        chk(stat_o.count, 16'h0000);
        chk(16'({stat_o.running, stat_o.init_done, chip_reset_o, reset_output_pin_n_o}), 16'h0009);
        tick(20);
        chk(16'(stat_o.count >= 16'h0009 && stat_o.count <= 16'h000B), 16'h0001);
    endtask
    task automatic t_reload;
        set_reload(8'hA5, 1'b0);
        pulse(M_SVC);
        drop;
        chk(stat_o.count, 16'hA500);
        tick(10);
        chk(16'(stat_o.count >= 16'hA504 && stat_o.count <= 16'hA505), 16'h0001);
        set_reload(8'hA5, 1'b1);
        pulse(M_SVC);
        drop;
        tick(199);
        chk(stat_o.count, 16'hA501);
    endtask
    task automatic t_overflow;
        set_reload(8'hFF, 1'b0);
        pulse(M_SVC);
        drop;
        n = 0;
        while (chip_reset_o !== 1'b1 && n < 600)
        begin
            tick(1);
            n++;
        end
        chk(16'(n >= 505 && n <= 520), 16'h0001);
        chk(16'(reset_output_pin_n_o), 16'h0000);
        chk(16'(stat_o.overflow), 16'h0001);
        n = 0;
        while (chip_reset_o === 1'b1 && n < 20)
        begin
            tick(1);
            n++;
        end
        chk(16'(n), 16'(PULSE));
        tick(1);
        chk({stat_o.running, stat_o.init_done, reset_output_pin_n_o}, 16'h0005);
        set_reload(8'hFF, 1'b0);
        repeat (4)
        begin
            pulse(M_SVC);
            drop;
            tick(400);
            chk(16'(chip_reset_o), 16'h0000);
            chk(16'(stat_o.count[15:8]), 16'h00FF);
        end
    endtask
    task automatic t_disable;
        do_reset;
        pulse(M_DIS);
        drop;
        chk(16'(stat_o.running), 16'h0000);
        seen = stat_o.count;
        tick(50);
        chk(stat_o.count, seen);
        do_reset;
        pulse(M_EOI);
        chk(16'(stat_o.init_done), 16'h0001);
        pulse(M_DIS);
        drop;
        chk(16'(stat_o.running), 16'h0001);
        clk_en_i = 1'b0;
        seen = stat_o.count;
        tick(20);
        chk(stat_o.count, seen);
        clk_en_i = 1'b1;
    endtask
    initial
    begin
        do_reset;
        t_defaults;
        t_reload;
        t_overflow;
        t_disable;
        wrap_up;
    end
    // run needs about 2450 cycles; allow ample margin
    initial
    begin
        #200000;
        failures++;
        wrap_up;
    end
endmodule
`default_nettype wire

// File: tb/wdrt_chk.sv
// Purpose : port checks of the watchdog reset timer
// Assumes : one clock domain, bound to wdrt_top
// Notes   : reset pulse width counted in helper logic
`timescale 1ns/100ps
`default_nettype none
module wdrt_chk
    import wdrt_pkg::*;
#(
    parameter int unsigned RST_PULSE_CYC = 2
)
(
    input wire logic                 core_clk_i,
    input wire logic                 rst_n_i,
    input wire logic                 clk_en_i,
    input wire wdrt_pkg::wdrt_ctrl_t ctrl_i,
    input wire logic                 chip_reset_o,
    input wire logic                 reset_output_pin_n_o,
    input wire wdrt_pkg::wdrt_stat_t stat_o
);
    logic [3:0] hi_cnt_r;
    logic [3:0] hi_cnt_nxt;
    logic       quiet;
    assign quiet = stat_o.running && !chip_reset_o && clk_en_i;
    // frozen with the design while the clock enable is low
    always_comb
    begin
        hi_cnt_nxt = hi_cnt_r;
        if (clk_en_i)
        begin
            hi_cnt_nxt = chip_reset_o ? hi_cnt_r + 4'h1 : 4'h0;
        end
    end
    always_ff @(posedge core_clk_i)
    begin
        hi_cnt_r <= rst_n_i ? hi_cnt_nxt : 4'h0;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_pin; reset_output_pin_n_o == !chip_reset_o; endproperty
    a_pin: assert property (p_pin) else $error("pin and reset differ");
    property p_ovf; $rose(chip_reset_o) |-> $past(stat_o.count) == 16'hFFFF; endproperty
    a_ovf: assert property (p_ovf) else $error("reset without overflow");
    property p_len; $fell(chip_reset_o) |-> hi_cnt_r == 4'(RST_PULSE_CYC); endproperty
    a_len: assert property (p_len) else $error("reset pulse length");
    property p_max; hi_cnt_r <= 4'(RST_PULSE_CYC); endproperty
    a_max: assert property (p_max) else $error("reset pulse too long");
    property p_svc; quiet && ctrl_i.service && !ctrl_i.disable_req |=> stat_o.count[7:0] == 8'h00; endproperty
    a_svc: assert property (p_svc) else $error("low byte not cleared");
    property p_step;
        quiet && !ctrl_i.service && !ctrl_i.disable_req && stat_o.count != 16'hFFFF
        |=> 16'(stat_o.count - $past(stat_o.count)) <= 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("count step");
    property p_div;
        quiet && $past(quiet) && $changed(stat_o.count) && !ctrl_i.service && !ctrl_i.disable_req
        && !$past(ctrl_i.service) |=> $stable(stat_o.count);
    endproperty
    a_div: assert property (p_div) else $error("count faster than half clock");
    property p_lock; stat_o.init_done && !chip_reset_o |=> stat_o.running || chip_reset_o; endproperty
    a_lock: assert property (p_lock) else $error("stopped after init end");
    property p_off;
        !stat_o.running && !chip_reset_o && !$past(chip_reset_o) && clk_en_i
        |=> !stat_o.running && $stable(stat_o.count);
    endproperty
    a_off: assert property (p_off) else $error("disabled timer moved");
    property p_rel;
        $rose(rst_n_i) |-> stat_o.count == 16'h0000 && stat_o.running && !stat_o.init_done && !chip_reset_o;
    endproperty
    a_rel: assert property (p_rel) else $error("reset defaults");
endmodule
bind wdrt_top wdrt_chk #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i), .ctrl_i(ctrl_i), .chip_reset_o(chip_reset_o),
    .reset_output_pin_n_o(reset_output_pin_n_o), .stat_o(stat_o));
`default_nettype wire
